// ---- design/bdio_port.sv ----
// Twelve channel buffered parallel I/O port on a processor transfer bus.
// Assumes instruction strobes synchronous to REF_CLK, one cycle each,
// and configuration software on an AXI4-Lite master.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "bdio_map.svh"

module bdio_port
  import bdio_pkg::*;
#(
  parameter int W = 12
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic IO_STROBE,
  input wire logic [11:0] IO_INSTR,
  input wire logic [W-1:0] IO_AC_IN,
  output logic [W-1:0] IO_AC_OUT,
  output logic IO_AC_LOAD,
  output logic IO_SKIP,
  output logic IO_IRQ,
  input wire logic [W-1:0] DATA_IN_N,
  output logic [W-1:0] DATA_OUT,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  typedef struct packed {
    logic [W-1:0] out_reg;
    logic [W-1:0] in_cap;
    logic [W-1:0] line_prev;
    logic int_en;
    logic irq;
    logic skip;
    logic ac_load;
    logic [W-1:0] ac_out;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;

  logic [2:0] dev_code;
  logic [W-1:0] level_mode;
  logic [W-1:0] isolate;
  logic [W-1:0] in_view;
  logic [W-1:0] fall;
  logic in_flag;
  io_op_t op;

  // Configuration words that stand in for the board jumpers
  bdio_cfg_regs #(
    .W(W)
  ) u_cfg (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .dev_code(dev_code),
    .level_mode(level_mode),
    .isolate(isolate),
    .out_view(st.out_reg),
    .in_view(in_view),
    .in_flag(in_flag),
    .int_en(st.int_en)
  );

  // Decoding only sees an instruction while its strobe is up
  assign op = IO_STROBE ? decode_op(IO_INSTR, dev_code) : OP_NONE;

  // Lines idle high; a high-to-low step is a captured one
  assign fall = st.line_prev & ~DATA_IN_N;

  // Each bit shows its flip-flop or the inverted live line
  assign in_view = (level_mode & ~DATA_IN_N) |
                   (~level_mode & st.in_cap);

  // Isolated bits take no part in flag, interrupt or skip
  assign in_flag = |(in_view & ~isolate);

  assign DATA_OUT = st.out_reg;
  assign IO_AC_OUT = st.ac_out;
  assign IO_AC_LOAD = st.ac_load;
  assign IO_SKIP = st.skip;
  assign IO_IRQ = st.irq;

  // Instruction execution and input capture
  always_comb begin
    next_st = st;
    next_st.line_prev = DATA_IN_N;
    next_st.ac_load = 1'b0;
    next_st.skip = 1'b0;
    next_st.ac_out = st.ac_out;
    unique case (op)
      OP_SET_OUT: next_st.out_reg = st.out_reg | IO_AC_IN;
      OP_CLR_OUT: next_st.out_reg = st.out_reg & ~IO_AC_IN;
      OP_RD_OUT: begin
        next_st.ac_out = st.out_reg;
        next_st.ac_load = 1'b1;
      end
      OP_RD_IN: begin
        next_st.ac_out = in_view;
        next_st.ac_load = 1'b1;
      end
      OP_CLR_IN: next_st.in_cap = st.in_cap & ~IO_AC_IN;
      OP_INT_OFF: next_st.int_en = 1'b0;
      OP_INT_ON: next_st.int_en = 1'b1;
      OP_SKIP_FLAG: next_st.skip = in_flag;
      OP_NONE: ;
    endcase
    // A fresh edge wins over a clear in the same cycle, so bits that
    // arrive between read and clear stay pending
    next_st.in_cap = next_st.in_cap | fall;
    // Request follows the enable at once, so enabling with a set flag
    // raises it on the next edge
    next_st.irq = next_st.int_en & in_flag;
  end

  // State register; system clear zeroes everything held except line_prev, which loads all ones
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st <= '0;
      st.line_prev <= `RST_LINES;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the instruction side
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_set_out;
    op == OP_SET_OUT |=> DATA_OUT == ($past(DATA_OUT) | $past(IO_AC_IN));
  endproperty
  a_set_out: assert property (p_set_out)
    else $error("set output bits wrong");

  property p_clr_out;
    op == OP_CLR_OUT |=> DATA_OUT == ($past(DATA_OUT) & ~$past(IO_AC_IN));
  endproperty
  a_clr_out: assert property (p_clr_out)
    else $error("clear output bits wrong");

  property p_out_hold;
    !(op inside {OP_SET_OUT, OP_CLR_OUT}) |=> $stable(DATA_OUT);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output register changed without instruction");

  property p_rd_out;
    op == OP_RD_OUT |=> IO_AC_LOAD && IO_AC_OUT == $past(DATA_OUT);
  endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("read output data wrong");

  property p_rd_in;
    op == OP_RD_IN |=> IO_AC_LOAD && IO_AC_OUT == $past(in_view) ##1
      (!IO_AC_LOAD || $past(op inside {OP_RD_IN, OP_RD_OUT}));
  endproperty
  a_rd_in: assert property (p_rd_in)
    else $error("read input data wrong");

  property p_edge_sticks;
    logic [W-1:0] e;
    (fall != '0, e = fall) |=> (st.in_cap & e) == e;
  endproperty
  a_edge_sticks: assert property (p_edge_sticks)
    else $error("captured edge lost");

  property p_ignore;
    IO_STROBE && !dev_match(IO_INSTR, dev_code) |=>
      !IO_AC_LOAD && !IO_SKIP && $stable(DATA_OUT) &&
      $stable(st.int_en);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("foreign device code acted on");

  property p_int_off;
    op == OP_INT_OFF |=> !st.int_en ##1
      (!IO_IRQ || $past(op == OP_INT_ON));
  endproperty
  a_int_off: assert property (p_int_off)
    else $error("interrupt not disabled");

  property p_int_on;
    op == OP_INT_ON && in_flag && $stable(DATA_IN_N) |=> IO_IRQ;
  endproperty
  a_int_on: assert property (p_int_on)
    else $error("enable with flag did not request");

  property p_skip;
    op == OP_SKIP_FLAG |=> IO_SKIP == $past(in_flag) ##1
      (!IO_SKIP || $past(op == OP_SKIP_FLAG));
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip does not follow flag");

  // Capture, read path and interrupt checks; results are registered, so
  // most of them compare one edge with the one before
  property p_clr_in;
    op == OP_CLR_IN |=>
      (st.in_cap & $past(IO_AC_IN) & ~$past(fall)) == '0;
  endproperty
  a_clr_in: assert property (p_clr_in)
    else $error("clear input left a bit set");

  property p_clr_keep;
    op == OP_CLR_IN |=>
      ($past(st.in_cap) & ~$past(IO_AC_IN) & ~st.in_cap) == '0;
  endproperty
  a_clr_keep: assert property (p_clr_keep)
    else $error("clear input dropped an unselected bit");

  property p_cap_hold;
    op != OP_CLR_IN |=> ($past(st.in_cap) & ~st.in_cap) == '0;
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("captured bit dropped without clear");

  property p_cap_from_fall;
    (st.in_cap & ~$past(st.in_cap) & ~$past(fall)) == '0;
  endproperty
  a_cap_from_fall: assert property (p_cap_from_fall)
    else $error("input bit captured without falling edge");

  property p_level_read;
    op == OP_RD_IN |=>
      ($past(level_mode) & (IO_AC_OUT ^ ~$past(DATA_IN_N))) == '0;
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("level bit did not show the live line");

  property p_edge_read;
    op == OP_RD_IN |=>
      (~$past(level_mode) & (IO_AC_OUT ^ $past(st.in_cap))) == '0;
  endproperty
  a_edge_read: assert property (p_edge_read)
    else $error("edge bit did not show its flip-flop");

  property p_irq_level;
    IO_IRQ == (st.int_en && $past(in_flag));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt request is not enable and flag");

  property p_int_on_sets;
    op == OP_INT_ON |=> st.int_en;
  endproperty
  a_int_on_sets: assert property (p_int_on_sets)
    else $error("interrupt enable not set");

  property p_en_hold;
    !(op inside {OP_INT_ON, OP_INT_OFF}) |=> $stable(st.int_en);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("interrupt enable changed by itself");

  property p_iso_skip;
    op == OP_SKIP_FLAG && (in_view & ~isolate) == '0 |=> !IO_SKIP;
  endproperty
  a_iso_skip: assert property (p_iso_skip)
    else $error("isolated input caused a skip");

  property p_ignore_data;
    IO_STROBE && !dev_match(IO_INSTR, dev_code) |=> $stable(IO_AC_OUT);
  endproperty
  a_ignore_data: assert property (p_ignore_data)
    else $error("foreign device code changed read data");

  property p_load_src;
    IO_AC_LOAD |-> $past(op inside {OP_RD_IN, OP_RD_OUT});
  endproperty
  a_load_src: assert property (p_load_src)
    else $error("accumulator load without a read");

  property p_skip_src;
    IO_SKIP |-> $past(op == OP_SKIP_FLAG);
  endproperty
  a_skip_src: assert property (p_skip_src)
    else $error("skip without a skip instruction");

  // Runs during reset itself, so it overrides the default disable
  property p_reset_clear;
    disable iff (1'b0)
    SYS_RST ##1 SYS_RST |-> DATA_OUT == '0 && !IO_IRQ && !st.int_en &&
      st.in_cap == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("system clear left state set");

  c_read_in: cover property (op == OP_RD_IN ##[1:8] op == OP_CLR_IN);
  c_irq: cover property (op == OP_INT_ON ##1 IO_IRQ);
  c_skip: cover property (op == OP_SKIP_FLAG ##1 IO_SKIP);
  c_set_clr: cover property (op == OP_SET_OUT ##[1:8] op == OP_CLR_OUT);
  c_foreign: cover property (IO_STROBE && !dev_match(IO_INSTR, dev_code));

endmodule

// ---- design/bdio_map.svh ----
// Constants of the buffered twelve channel parallel I/O port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BDIO_MAP_SVH
`define BDIO_MAP_SVH

// Transfer instruction fields: opcode, device code high digit, functions
`define IOT_OPCODE 3'h6
`define DEV_HIGH_DIGIT 3'h5
`define FN_INT_OFF 3'h0
`define FN_INT_ON 3'h1
`define FN_SKIP_FLAG 3'h2
`define FN_CLR_IN 3'h3
`define FN_RD_IN 3'h4
`define FN_SET_OUT 3'h5
`define FN_CLR_OUT 3'h6
`define FN_RD_OUT 3'h7

// Configuration register byte addresses on the AXI4-Lite slave
`define ADDR_DEV_CODE 8'h00
`define ADDR_LEVEL_MODE 8'h04
`define ADDR_ISOLATE 8'h08
`define ADDR_OUT_VIEW 8'h0C
`define ADDR_IN_VIEW 8'h10
`define ADDR_STATUS 8'h14

// Reset values and bus responses
`define RST_DEV_CODE 3'h0
`define RST_WORD 12'h000
`define RST_LINES 12'hFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- design/bdio_pkg.sv ----
// Types and instruction decode shared by the parallel I/O port modules.
// Assumes bdio_map.svh on the include path.
`include "bdio_map.svh"

package bdio_pkg;

  // Decoded transfer instruction
  typedef enum logic [3:0] {
    OP_NONE, OP_INT_OFF, OP_INT_ON, OP_SKIP_FLAG, OP_CLR_IN,
    OP_RD_IN, OP_SET_OUT, OP_CLR_OUT, OP_RD_OUT
  } io_op_t;

  // Device field match: high digit fixed, low digit from the selection
  function automatic logic dev_match(input logic [11:0] instr,
                                     input logic [2:0] code);
    dev_match = (instr[11:9] == `IOT_OPCODE) &&
                (instr[8:6] == `DEV_HIGH_DIGIT) && (instr[5:3] == code);
  endfunction

  // Function field to operation
  function automatic io_op_t decode_op(input logic [11:0] instr,
                                       input logic [2:0] code);
    io_op_t op;
    op = OP_NONE;
    if (dev_match(instr, code)) begin
      unique case (instr[2:0])
        `FN_INT_OFF: op = OP_INT_OFF;
        `FN_INT_ON: op = OP_INT_ON;
        `FN_SKIP_FLAG: op = OP_SKIP_FLAG;
        `FN_CLR_IN: op = OP_CLR_IN;
        `FN_RD_IN: op = OP_RD_IN;
        `FN_SET_OUT: op = OP_SET_OUT;
        `FN_CLR_OUT: op = OP_CLR_OUT;
        `FN_RD_OUT: op = OP_RD_OUT;
      endcase
    end
    decode_op = op;
  endfunction

endpackage

// ---- design/bdio_cfg_regs.sv ----
// AXI4-Lite slave holding the strap-like configuration of the port.
// Assumes a single-clock system and a master with one access of each kind.
`include "bdio_map.svh"

module bdio_cfg_regs
  import bdio_pkg::*;
#(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [2:0] dev_code,
  output logic [W-1:0] level_mode,
  output logic [W-1:0] isolate,
  input wire logic [W-1:0] out_view,
  input wire logic [W-1:0] in_view,
  input wire logic in_flag,
  input wire logic int_en
);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] dev_code;
    logic [W-1:0] level_mode;
    logic [W-1:0] isolate;
  } cfg_state_t;

  cfg_state_t st;
  cfg_state_t next_st;

  // Apply byte lanes to a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // Address and data are taken apart; a new one waits for the response
  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign dev_code = st.dev_code;
  assign level_mode = st.level_mode;
  assign isolate = st.isolate;

  // Next state of both channels and the configuration words
  always_comb begin
    logic [31:0] m;
    m = '0;
    next_st = st;
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RESP_OKAY;
      unique case (st.waddr)
        `ADDR_DEV_CODE: begin
          m = merge(32'h0000_0000 | st.dev_code, st.wdata, st.wstrb);
          next_st.dev_code = m[2:0];
        end
        `ADDR_LEVEL_MODE: begin
          m = merge(32'h0000_0000 | st.level_mode, st.wdata, st.wstrb);
          next_st.level_mode = m[W-1:0];
        end
        `ADDR_ISOLATE: begin
          m = merge(32'h0000_0000 | st.isolate, st.wdata, st.wstrb);
          next_st.isolate = m[W-1:0];
        end
        `ADDR_OUT_VIEW, `ADDR_IN_VIEW, `ADDR_STATUS: ;
        default: next_st.bresp = `RESP_SLVERR;
      endcase
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      unique case (araddr)
        `ADDR_DEV_CODE: next_st.rdata[2:0] = st.dev_code;
        `ADDR_LEVEL_MODE: next_st.rdata[W-1:0] = st.level_mode;
        `ADDR_ISOLATE: next_st.rdata[W-1:0] = st.isolate;
        `ADDR_OUT_VIEW: next_st.rdata[W-1:0] = out_view;
        `ADDR_IN_VIEW: next_st.rdata[W-1:0] = in_view;
        `ADDR_STATUS: next_st.rdata[1:0] = {int_en, in_flag};
        default: next_st.rresp = `RESP_SLVERR;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.dev_code <= `RST_DEV_CODE;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ---- testbench/proc_model.sv ----
// Processor model that issues transfer instructions to the port.
// Assumes one instruction at a time, launched on the shared clock.
`include "bdio_map.svh"

module proc_model #(
  parameter int W = 12
) (
  input wire logic clk,
  output logic strobe,
  output logic [11:0] instr,
  output logic [W-1:0] ac_in,
  input wire logic [W-1:0] ac_out,
  input wire logic ac_load,
  input wire logic skip
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus before the first instruction
  initial begin
    strobe = 1'b0;
    instr = 12'h000;
    ac_in = '0;
  end

  // Gap sets a prompt or slow issue; a released bus shows the inverse
  // so a stale instruction cannot look valid by accident
  task automatic exec(input logic [2:0] dev, input logic [2:0] fn,
                      input logic [W-1:0] ac, input int gap,
                      output logic [W-1:0] data, output logic [1:0] pls);
    repeat (gap + 1) @(posedge clk);
    strobe <= 1'b1;
    instr <= {`IOT_OPCODE, `DEV_HIGH_DIGIT, dev, fn};
    ac_in <= ac;
    @(posedge clk);
    strobe <= 1'b0;
    instr <= ~{`IOT_OPCODE, `DEV_HIGH_DIGIT, dev, fn};
    ac_in <= ~ac;
    @(negedge clk);
    data = ac_out;
    pls = {ac_load, skip};
  endtask
endmodule

// ---- testbench/buffered_parallel_io_12ch_bench.sv ----
// Self-checking bench of the twelve channel parallel I/O port.
// Assumes the processor model as instruction source, AXI4-Lite tasks here.
`include "bdio_map.svh"
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin \
  n_errors++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module buffered_parallel_io_12ch_bench import bdio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic io_strobe, io_ac_load, io_skip, io_irq;
  logic [11:0] io_instr, io_ac_in, io_ac_out, data_in_n, data_out;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, rs, p;
  logic [11:0] exp_out, cap, v, m, d;
  int n_errors = 0;
  int total_checks = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  bdio_port #(.W(12)) DUT (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .IO_STROBE(io_strobe),
    .IO_INSTR(io_instr), .IO_AC_IN(io_ac_in), .IO_AC_OUT(io_ac_out),
    .IO_AC_LOAD(io_ac_load), .IO_SKIP(io_skip), .IO_IRQ(io_irq),
    .DATA_IN_N(data_in_n), .DATA_OUT(data_out),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  proc_model #(.W(12)) proc (
    .clk(ref_clk), .strobe(io_strobe), .instr(io_instr), .ac_in(io_ac_in),
    .ac_out(io_ac_out), .ac_load(io_ac_load), .skip(io_skip)
  );

  // Expected output register after a set or clear instruction
  function automatic logic [11:0] out_next(logic [11:0] o, logic set,
                                           logic [11:0] ac);
    return set ? (o | ac) : (o & ~ac);
  endfunction

  // Write: both channels offered together, each released at its handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat,
                        output logic [1:0] resp);
    logic pa = 1'b1;
    logic pw = 1'b1;
    logic ta, tw;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge ref_clk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge ref_clk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask

  // Read: address held until taken, rready held until data arrives
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat,
                        output logic [1:0] resp);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge ref_clk); while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask

  // Instruction with a random idle gap before it
  task automatic run(input logic [2:0] dev, input logic [2:0] fn,
                     input logic [11:0] ac);
    proc.exec(dev, fn, ac, $urandom_range(2), d, p);
  endtask

  // Drive the lines, then leave a cycle for the edge detector
  task automatic lines(input logic [11:0] val);
    @(posedge ref_clk);
    data_in_n <= val;
    @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    data_in_n = 12'hFFF;
    rd = $urandom(96186);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    `CHK("out_reset", 12'h000, data_out)
    `CHK("irq_reset", 1'b0, io_irq)
    axi_rd(`ADDR_STATUS, rd, rs);
    `CHK("status_reset", 32'h0000_0000, rd)
    axi_rd(`ADDR_DEV_CODE, rd, rs);
    `CHK("dev_default", 32'h0000_0000, rd)
    $display("test reset done");
    exp_out = 12'h000;
    for (int i = 0; i < 10; i++) begin
      v = (i < 2) ? 12'hFFF : 12'($urandom);
      run(3'h0, i[0] ? `FN_CLR_OUT : `FN_SET_OUT, v);
      exp_out = out_next(exp_out, !i[0], v);
      `CHK("out_reg", exp_out, data_out)
      run(3'h0, `FN_RD_OUT, v);
      `CHK("rd_out", {2'b10, exp_out}, {p, d})
    end
    run(3'h1, `FN_SET_OUT, 12'hFFF);
    `CHK("foreign_dev", {2'b00, exp_out}, {p, data_out})
    $display("test outputs done");
    cap = 12'($urandom) | 12'h001;
    lines(~cap);
    lines(12'hFFF);
    run(3'h0, `FN_RD_IN, 12'h000);
    `CHK("rd_in", {2'b10, cap}, {p, d})
    v = 12'($urandom) & ~cap;
    lines(~v);
    lines(12'hFFF);
    run(3'h0, `FN_CLR_IN, cap);
    run(3'h0, `FN_RD_IN, 12'h000);
    `CHK("clr_in", v, d)
    run(3'h0, `FN_CLR_IN, 12'hFFF);
    $display("test latched inputs done");
    m = 12'($urandom);
    v = 12'($urandom);
    axi_wr(`ADDR_LEVEL_MODE, {20'h0_0000, m}, rs);
    lines(~v);
    run(3'h0, `FN_RD_IN, 12'h000);
    `CHK("level_low", v, d)
    lines(12'hFFF);
    run(3'h0, `FN_RD_IN, 12'h000);
    `CHK("level_released", v & ~m, d)
    run(3'h0, `FN_CLR_IN, 12'hFFF);
    axi_wr(`ADDR_LEVEL_MODE, 32'h0000_0000, rs);
    $display("test level inputs done");
    run(3'h0, `FN_SKIP_FLAG, 12'h000);
    `CHK("no_skip", 2'b00, p)
    lines(12'hFF7);
    lines(12'hFFF);
    run(3'h0, `FN_SKIP_FLAG, 12'h000);
    `CHK("skip", 2'b01, p)
    `CHK("irq_disabled", 1'b0, io_irq)
    run(3'h0, `FN_INT_ON, 12'h000);
    repeat (3) @(negedge ref_clk);
    `CHK("irq_on", 1'b1, io_irq)
    axi_rd(`ADDR_STATUS, rd, rs);
    `CHK("status", 32'h0000_0003, rd)
    run(3'h0, `FN_INT_OFF, 12'h000);
    repeat (3) @(negedge ref_clk);
    `CHK("irq_off", 1'b0, io_irq)
    axi_wr(`ADDR_ISOLATE, 32'h0000_0008, rs);
    run(3'h0, `FN_SKIP_FLAG, 12'h000);
    `CHK("iso_skip", 2'b00, p)
    run(3'h0, `FN_INT_ON, 12'h000);
    repeat (3) @(negedge ref_clk);
    `CHK("iso_irq", 1'b0, io_irq)
    axi_wr(`ADDR_ISOLATE, 32'h0000_0000, rs);
    repeat (3) @(negedge ref_clk);
    `CHK("irq_joined", 1'b1, io_irq)
    run(3'h0, `FN_CLR_IN, 12'h008);
    repeat (3) @(negedge ref_clk);
    `CHK("irq_cleared", 1'b0, io_irq)
    run(3'h0, `FN_INT_OFF, 12'h000);
    $display("test interrupt done");
    for (int c = 0; c < 8; c++) begin
      axi_wr(`ADDR_DEV_CODE, 32'(c), rs);
      run(3'(c + 1), `FN_SET_OUT, 12'hFFF);
      run(3'(c), `FN_SET_OUT, 12'(1 << c));
      exp_out = out_next(exp_out, 1'b1, 12'(1 << c));
      `CHK("dev_code", exp_out, data_out)
    end
    axi_wr(`ADDR_DEV_CODE, 32'h0000_0000, rs);
    $display("test device codes done");
    axi_rd(8'h18, rd, rs);
    `CHK("unmapped_rd", {`RESP_SLVERR, 32'h0000_0000}, {rs, rd})
    axi_wr(8'h18, 32'h0000_FFFF, rs);
    `CHK("unmapped_wr", `RESP_SLVERR, rs)
    axi_wr(`ADDR_OUT_VIEW, 32'h0000_0000, rs);
    axi_rd(`ADDR_OUT_VIEW, rd, rs);
    `CHK("ro_view", {`RESP_OKAY, 20'h0_0000, exp_out}, {rs, rd})
    $display("test register bus done");
    run(3'h0, `FN_INT_ON, 12'h000);
    lines(12'hFFE);
    lines(12'hFFF);
    axi_wr(`ADDR_DEV_CODE, 32'h0000_0005, rs);
    @(negedge ref_clk);
    `CHK("irq_before_clear", 1'b1, io_irq)
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    `CHK("out_clear", 12'h000, data_out)
    `CHK("irq_clear", 1'b0, io_irq)
    axi_rd(`ADDR_DEV_CODE, rd, rs);
    `CHK("dev_clear", 32'h0000_0000, rd)
    run(3'h0, `FN_RD_IN, 12'h000);
    `CHK("in_clear", {2'b10, 12'h000}, {p, d})
    $display("test system clear done");
    give_verdict();
  end
endmodule
